// [logic/pss_regs.svh]
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

`define PSS_CMD_ON_DELAY 8'h60
`define PSS_CMD_RISE_TIME 8'h61
`define PSS_CMD_SUM_LOW 8'h78
`define PSS_CMD_SUM_FULL 8'h79
`define PSS_CMD_VOUT_FLAGS 8'h7a
`define PSS_CMD_IOUT_FLAGS 8'h7b
`define PSS_CMD_CLEAR_FAULTS 8'h03

`define PSS_ON_DELAY_RESET 16'h0000
`define PSS_ON_DELAY_MAX 11'h100
`define PSS_ON_DELAY_W 11
`define PSS_RISE_RESET 16'h0001
`define PSS_RISE_W 3

`define PSS_RISE_CODE_1MS 3'h0
`define PSS_RISE_CODE_2MS 3'h1
`define PSS_RISE_CODE_4MS 3'h2
`define PSS_RISE_CODE_8MS 3'h3
`define PSS_RISE_MS_1 24'h000001
`define PSS_RISE_MS_2 24'h000002
`define PSS_RISE_MS_4 24'h000004
`define PSS_RISE_MS_8 24'h000008
`define PSS_RISE_MS_16 24'h000010

`define PSS_SUM_OFF_BIT 6
`define PSS_SUM_OV_BIT 5
`define PSS_SUM_OC_BIT 4
`define PSS_SUM_TEMP_BIT 2
`define PSS_SUM_COMM_BIT 1
`define PSS_SUM_OTHER_BIT 0
`define PSS_WORD_VOUT_BIT 15
`define PSS_WORD_IOUT_BIT 14
`define PSS_WORD_VIN_BIT 13
`define PSS_WORD_PG_N_BIT 11
`define PSS_WORD_UNK_BIT 8
`define PSS_VOUT_OV_BIT 7
`define PSS_VOUT_UV_BIT 4
`define PSS_VOUT_RANGE_BIT 3
`define PSS_IOUT_OC_BIT 7
`define PSS_IOUT_OC_UV_BIT 6
`define PSS_IOUT_WARN_BIT 5

`define PSS_DELAY_LSB_MS 4
`define PSS_CLK_HZ 50000000
`define PSS_MS_CYCLES (`PSS_CLK_HZ / 1000)

`endif

// [logic/pss_pkg.sv]
package pss_pkg;

  typedef enum logic [1:0] {
    PSS_OFF,
    PSS_DELAY,
    PSS_RAMP,
    PSS_ON
  } pss_phase_t;

  typedef struct packed {
    logic oc_fault;
    logic oc_warn;
    logic ov_fault;
    logic uv_fault;
    logic ot_fault;
    logic ot_warn;
    logic bad_fet;
    logic vin_below_uvlo;
    logic power_good;
    logic vout_range_err;
    logic comm_error;
    logic other_warn;
    logic other_fault;
  } pss_cond_t;

  typedef struct packed {
    logic [15:0] on_delay;
    logic [15:0] rise_code;
    logic oc_latch;
    logic ov_latch;
    logic comm_latch;
    logic unk_latch;
    pss_phase_t phase;
    logic [23:0] ms_cnt;
    logic [15:0] tick_cnt;
    logic [15:0] rd_data;
    logic rd_valid;
    logic enable_out;
    logic ramp_active;
  } pss_state_t;

endpackage : pss_pkg

// [logic/pss_regs_core.sv]
`timescale 1ns/1ps
`include "pss_regs.svh"

// Summary of operation
// - Turn-on delay is bits 10..0 unsigned, 4 ms each; bits 15..11 read-only.
// - Turn-on delay accepts at most 0x0100 and resets to zero.
// - Delay runs from start condition until output begins to rise.
// - Soft-start setting is the rise time to regulation.
// - Soft-start codes 0..3 give 1,2,4,8 ms; 4 and up give 16 ms.
// - Soft-start setting resets to 0x0001, a 2 ms ramp.
// - Latched flags clear only once the cause is gone and fault-clear arrives.
// - Summary byte bits 3 and 7 always read zero.
// - Summary bit 6 is live one whenever the output is disabled.
// - Summary bit 4 latches overcurrent; bit 5 shows overvoltage occurred.
// - Summary bit 2 is live overtemperature warning or fault.
// - Summary bit 1 latches a management bus communication error.
// - Summary bit 0 is live for any other fault or warning.
// - Low byte of the summary word equals the summary byte.
// - Word bit 15 is live output voltage status, bit 14 current fault.
// - Word bit 13 is one until input passes undervoltage lockout.
// - Word bit 11 is zero while power-good is asserted.
// - Word bit 8 latches any fault not reported elsewhere.
// - Voltage flags: overvoltage bit 7, undervoltage bit 4, live.
// - Voltage flags bit 3 reports an out-of-range output voltage request.
// - Current flags: fault bit 7, fault with UV bit 6, warning bit 5.
module pss_regs_core #(
  parameter int unsigned MS_CYCLES = `PSS_MS_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] cmd,
  input wire logic [15:0] wr_data,
  input wire logic start_req,
  input wire logic op_on,
  input wire pss_pkg::pss_cond_t cond,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic enable_out,
  output logic ramp_active
);

  pss_pkg::pss_state_t st;
  pss_pkg::pss_state_t next_st;

  logic [7:0] sum_low;
  logic [15:0] sum_full;
  logic [7:0] vout_flags;
  logic [7:0] iout_flags;
  logic out_disabled;
  logic shutdown;
  logic abort;
  logic clear_cmd;
  logic delay_wr;
  logic rise_wr;
  logic delay_ok;
  logic start_ok;
  logic delay_zero;
  logic timing;
  logic tick_wrap;
  logic delay_done;
  logic ramp_done;
  logic [15:0] read_word;
  logic [23:0] delay_ms;
  logic [23:0] ramp_ms;

  // Ramp length in ms from the three-bit soft-start code.
  function automatic logic [23:0] rise_ms(input logic [15:0] code);
    logic [`PSS_RISE_W-1:0] c;
    c = code[`PSS_RISE_W-1:0];
    unique case (c)
      `PSS_RISE_CODE_1MS: begin
        rise_ms = `PSS_RISE_MS_1;
      end
      `PSS_RISE_CODE_2MS: begin
        rise_ms = `PSS_RISE_MS_2;
      end
      `PSS_RISE_CODE_4MS: begin
        rise_ms = `PSS_RISE_MS_4;
      end
      `PSS_RISE_CODE_8MS: begin
        rise_ms = `PSS_RISE_MS_8;
      end
      // Every code from four upwards selects the longest ramp.
      default: begin
        rise_ms = `PSS_RISE_MS_16;
      end
    endcase
  endfunction : rise_ms

  // Any condition that forces the output off, also used to abort a sequence.
  function automatic logic is_shutdown(input pss_pkg::pss_cond_t c);
    is_shutdown = c.oc_fault
      || c.ot_fault
      || c.bad_fet
      || c.uv_fault
      || c.ov_fault;
  endfunction : is_shutdown

  // A new event wins over a simultaneous clear; a standing cause keeps the flag.
  function automatic logic latch_next(
    input logic cur,
    input logic cause,
    input logic clear
  );
    if (cause) begin
      latch_next = 1'b1;
    end else if (clear) begin
      latch_next = 1'b0;
    end else begin
      latch_next = cur;
    end
  endfunction : latch_next

  // Places a byte-wide register image in the low half of the read word.
  function automatic logic [15:0] byte_word(input logic [7:0] b);
    byte_word = {8'h00, b};
  endfunction : byte_word

  // Write and clear strobes each decode one command code.
  function automatic logic cmd_hit(
    input logic en,
    input logic [7:0] c,
    input logic [7:0] code
  );
    cmd_hit = en && (c == code);
  endfunction : cmd_hit

  // Out-of-range delays are dropped so the stored value never exceeds the limit.
  function automatic logic delay_limit_ok(input logic [15:0] d);
    delay_limit_ok = (d[`PSS_ON_DELAY_W-1:0] <= `PSS_ON_DELAY_MAX);
  endfunction : delay_limit_ok

  // Delay setting in ms; the product cannot overflow for any stored setting.
  function automatic logic [23:0] delay_to_ms(input logic [15:0] d);
    delay_to_ms = 24'(d) * 24'(`PSS_DELAY_LSB_MS);
  endfunction : delay_to_ms

  // Strobe decode and sequencing conditions.
  assign clear_cmd = cmd_hit(wr_en, cmd, `PSS_CMD_CLEAR_FAULTS);
  assign delay_wr = cmd_hit(wr_en, cmd, `PSS_CMD_ON_DELAY);
  assign rise_wr = cmd_hit(wr_en, cmd, `PSS_CMD_RISE_TIME);
  assign delay_ok = delay_limit_ok(wr_data);
  assign shutdown = is_shutdown(cond);
  assign abort = !op_on || shutdown;
  assign out_disabled = !st.enable_out || shutdown;
  assign start_ok = start_req && op_on;
  assign delay_zero = (st.on_delay == `PSS_ON_DELAY_RESET);
  assign timing = (st.phase == pss_pkg::PSS_DELAY) || (st.phase == pss_pkg::PSS_RAMP);

  // MS_CYCLES is a parameter so that simulation can run with a short millisecond.
  assign tick_wrap = (st.tick_cnt == 16'(MS_CYCLES - 1));
  assign delay_ms = delay_to_ms(st.on_delay);
  assign ramp_ms = rise_ms(st.rise_code);
  assign delay_done = (st.ms_cnt >= delay_ms);
  assign ramp_done = (st.ms_cnt >= ramp_ms);

  // Summary byte image; reserved positions stay zero.
  always_comb begin
    sum_low = 8'h00;
    sum_low[`PSS_SUM_OFF_BIT] = out_disabled;
    sum_low[`PSS_SUM_OV_BIT] = st.ov_latch;
    sum_low[`PSS_SUM_OC_BIT] = st.oc_latch;
    sum_low[`PSS_SUM_TEMP_BIT] = cond.ot_fault
      || cond.ot_warn;
    sum_low[`PSS_SUM_COMM_BIT] = st.comm_latch;
    sum_low[`PSS_SUM_OTHER_BIT] = cond.other_warn
      || cond.other_fault;
  end

  always_comb begin
    sum_full = byte_word(sum_low);
    sum_full[`PSS_WORD_VOUT_BIT] = cond.ov_fault
      || cond.uv_fault
      || cond.vout_range_err;
    sum_full[`PSS_WORD_IOUT_BIT] = cond.oc_fault;
    sum_full[`PSS_WORD_VIN_BIT] = cond.vin_below_uvlo;
    sum_full[`PSS_WORD_PG_N_BIT] = !cond.power_good;
    sum_full[`PSS_WORD_UNK_BIT] = st.unk_latch;
  end

  // Voltage and current flag images are live copies of the conditions.
  always_comb begin
    vout_flags = 8'h00;
    vout_flags[`PSS_VOUT_OV_BIT] = cond.ov_fault;
    vout_flags[`PSS_VOUT_UV_BIT] = cond.uv_fault;
    vout_flags[`PSS_VOUT_RANGE_BIT] = cond.vout_range_err;
  end

  always_comb begin
    iout_flags = 8'h00;
    iout_flags[`PSS_IOUT_OC_BIT] = cond.oc_fault;
    iout_flags[`PSS_IOUT_OC_UV_BIT] = cond.oc_fault
      && cond.uv_fault;
    iout_flags[`PSS_IOUT_WARN_BIT] = cond.oc_warn;
  end

  // Unknown command codes read as zero rather than as stale data.
  always_comb begin
    unique case (cmd)
      `PSS_CMD_ON_DELAY: begin
        read_word = st.on_delay;
      end
      `PSS_CMD_RISE_TIME: begin
        read_word = st.rise_code;
      end
      `PSS_CMD_SUM_LOW: begin
        read_word = byte_word(sum_low);
      end
      `PSS_CMD_SUM_FULL: begin
        read_word = sum_full;
      end
      `PSS_CMD_VOUT_FLAGS: begin
        read_word = byte_word(vout_flags);
      end
      `PSS_CMD_IOUT_FLAGS: begin
        read_word = byte_word(iout_flags);
      end
      default: begin
        read_word = 16'h0000;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;

    // Register writes; read-only positions are never stored.
    if (delay_wr && delay_ok) begin
      next_st.on_delay = {5'h00, wr_data[`PSS_ON_DELAY_W-1:0]};
    end
    if (rise_wr) begin
      next_st.rise_code = {13'h0000, wr_data[`PSS_RISE_W-1:0]};
    end

    // Latched status bits.
    next_st.oc_latch = latch_next(
      st.oc_latch,
      cond.oc_fault,
      clear_cmd
    );
    next_st.ov_latch = latch_next(
      st.ov_latch,
      cond.ov_fault,
      clear_cmd
    );
    next_st.comm_latch = latch_next(
      st.comm_latch,
      cond.comm_error,
      clear_cmd
    );
    next_st.unk_latch = latch_next(
      st.unk_latch,
      cond.other_fault,
      clear_cmd
    );

    // Read data is captured once and held until the next read.
    if (rd_en) begin
      next_st.rd_valid = 1'b1;
      next_st.rd_data = read_word;
    end

    // Millisecond tick shared by delay and ramp timing.
    if (timing) begin
      if (tick_wrap) begin
        next_st.tick_cnt = 16'h0000;
        next_st.ms_cnt = st.ms_cnt + 24'h000001;
      end else begin
        next_st.tick_cnt = st.tick_cnt + 16'h0001;
      end
    end

    unique case (st.phase)
      pss_pkg::PSS_OFF: begin
        next_st.tick_cnt = 16'h0000;
        next_st.ms_cnt = 24'h000000;
        // A zero delay goes straight to the ramp.
        if (start_ok) begin
          if (delay_zero) begin
            next_st.phase = pss_pkg::PSS_RAMP;
            next_st.ramp_active = 1'b1;
          end else begin
            next_st.phase = pss_pkg::PSS_DELAY;
          end
        end
      end
      pss_pkg::PSS_DELAY: begin
        if (delay_done) begin
          next_st.phase = pss_pkg::PSS_RAMP;
          next_st.ramp_active = 1'b1;
          next_st.ms_cnt = 24'h000000;
          next_st.tick_cnt = 16'h0000;
        end
      end
      pss_pkg::PSS_RAMP: begin
        // The output is enabled from the second cycle of the ramp on, not only once in regulation.
        next_st.enable_out = 1'b1;
        if (ramp_done) begin
          next_st.phase = pss_pkg::PSS_ON;
          next_st.ramp_active = 1'b0;
          next_st.tick_cnt = 16'h0000;
          next_st.ms_cnt = 24'h000000;
        end
      end
      pss_pkg::PSS_ON: begin
        next_st.enable_out = 1'b1;
        next_st.tick_cnt = 16'h0000;
        next_st.ms_cnt = 24'h000000;
      end
    endcase

    // Turning off or any shutdown fault aborts the sequence at once.
    if (abort) begin
      next_st.phase = pss_pkg::PSS_OFF;
      next_st.enable_out = 1'b0;
      next_st.ramp_active = 1'b0;
    end
  end

  // The reset branch loads constants only.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.on_delay <= `PSS_ON_DELAY_RESET;
      st.rise_code <= `PSS_RISE_RESET;
      st.phase <= pss_pkg::PSS_OFF;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign enable_out = st.enable_out;
  assign ramp_active = st.ramp_active;

endmodule : pss_regs_core

// [tb/pss_regs_core_asserts.sv]
`timescale 1ns/1ps
module pss_chk #(
  parameter int unsigned MS_CYCLES = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rd_en,
  input wire logic [7:0] cmd,
  input wire logic op_on,
  input wire pss_pkg::pss_cond_t cond,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic enable_out,
  input wire logic ramp_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rdv; rd_en |=> rd_valid; endproperty
  a_rdv: assert property (p_rdv) else $error("read not answered");
  property p_sum; rd_en && cmd == 8'h78 |=> rd_data[15:7] == 9'h0 && !rd_data[3]; endproperty
  a_sum: assert property (p_sum) else $error("summary reserved bit set");
  property p_off; rd_en && cmd == 8'h78 && !enable_out |=> rd_data[6]; endproperty
  a_off: assert property (p_off) else $error("off flag low");
  property p_ot; rd_en && cmd == 8'h78 |=> rd_data[2] == $past(cond.ot_fault | cond.ot_warn);
  endproperty
  a_ot: assert property (p_ot) else $error("temperature flag wrong");
  property p_pg; rd_en && cmd == 8'h79 |=> rd_data[11] == !$past(cond.power_good); endproperty
  a_pg: assert property (p_pg) else $error("power good flag wrong");
  property p_vo; rd_en && cmd == 8'h7a |=> rd_data[7] == $past(cond.ov_fault)
    && rd_data[4] == $past(cond.uv_fault); endproperty
  a_vo: assert property (p_vo) else $error("voltage flags wrong");
  property p_io; rd_en && cmd == 8'h7b |=> rd_data[5:0] == {$past(cond.oc_warn), 5'h00};
  endproperty
  a_io: assert property (p_io) else $error("current flags wrong");
  property p_rise; rd_en && cmd == 8'h61 |=> rd_data[15:3] == 13'h0000; endproperty
  a_rise: assert property (p_rise) else $error("soft-start high bits set");
  c_rd: cover property (rd_en && cmd == 8'h78 && op_on);
  c_ramp: cover property ($rose(ramp_active));
  c_on: cover property ($rose(enable_out));
endmodule : pss_chk

bind pss_regs_core pss_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk), .nrst(nrst),
  .rd_en(rd_en), .cmd(cmd), .op_on(op_on), .cond(cond), .rd_data(rd_data),
  .rd_valid(rd_valid), .enable_out(enable_out), .ramp_active(ramp_active));

// [tb/pss_host.sv]
`timescale 1ns/1ps
module pss_host (
  input wire logic clk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] cmd,
  output logic [15:0] wr_data
);
  initial {wr_en, rd_en, cmd, wr_data} = 26'h0;
  // A missing answer yields unknowns so that it can never match.
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk) {wr_en, cmd, wr_data} = {1'b1, c, d};
    @(negedge clk) {wr_en, wr_data} = {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(negedge clk) {rd_en, cmd} = {1'b1, c};
    @(negedge clk) rd_en = 1'b0;
    d = rd_valid ? rd_data : 16'hxxxx;
  endtask : rd
endmodule : pss_host

// [tb/pss_regs_core_tb_top.sv]
`timescale 1ns/1ps
module pss_regs_core_tb_top;
  logic clk, nrst, start_req, op_on, wr_en, rd_en, rd_valid, enable_out, ramp_active;
  logic [7:0] cmd;
  logic [15:0] wr_data, rd_data, v;
  pss_pkg::pss_cond_t cond;
  int failures, checked, n, e;
  logic [40:0] rows [9] = '{{1'b0, 8'h60, 32'h0}, {1'b0, 8'h61, 32'h1},
    {1'b1, 8'h60, 32'hffff0000}, {1'b0, 8'h60, 32'h0}, {1'b1, 8'h60, 32'hf9000000},
    {1'b0, 8'h60, 32'h100}, {1'b1, 8'h61, 32'hfffc0000}, {1'b0, 8'h61, 32'h4},
    {1'b0, 8'h7b, 32'h0}};
  pss_regs_core #(.MS_CYCLES(10)) dut (.clk(clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en),
    .cmd(cmd), .wr_data(wr_data), .start_req(start_req), .op_on(op_on), .cond(cond),
    .rd_data(rd_data), .rd_valid(rd_valid), .enable_out(enable_out), .ramp_active(ramp_active));
  pss_host host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en),
    .rd_en(rd_en), .cmd(cmd), .wr_data(wr_data));
  task automatic check(input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask : check
  task automatic rc(input logic [7:0] c, input logic [15:0] x);
    host.rd(c, v);
    check(v, x);
  endtask : rc
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
  initial begin
    {nrst, start_req, op_on, cond} = 16'h0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i]) begin
      if (rows[i][40]) host.wr(rows[i][39:32], rows[i][31:16]);
      else rc(rows[i][39:32], rows[i][15:0]);
    end
    $display("register table ended");
    host.wr(8'h60, 16'h0001);
    for (int k = 0; k < 6; k++) begin
      host.wr(8'h61, 16'(k + k / 5));
      e = 10 * (k > 3 ? 16 : 1 << k);
      n = 0;
      {start_req, op_on} = 2'b11;
      while (!ramp_active && n < 99) @(negedge clk) n++;
      check(16'(n > 37 && n < 44), 16'h1);
      n = 0;
      while (ramp_active && n < 300) @(negedge clk) n++;
      check(16'(n >= e - 2 && n <= e + 2), 16'h1);
      check({15'h0, enable_out}, 16'h1);
      rc(8'h78, 16'h0000);
      {start_req, op_on} = 2'b00;
    end
    $display("sequencing ended");
    // Clearing while the causes persist must leave the latches set.
    cond = 13'h1005;
    host.wr(8'h03, 16'h0);
    rc(8'h78, 16'h0053);
    rc(8'h79, 16'h4953);
    cond = 13'h0010;
    rc(8'h78, 16'h0052);
    host.wr(8'h03, 16'h0);
    rc(8'h79, 16'h0040);
    cond = 13'h02a8;
    rc(8'h7a, 16'h0018);
    rc(8'h79, 16'ha844);
    cond = 13'h1a00;
    rc(8'h7b, 16'h00e0);
    cond = 13'h0400;
    rc(8'h78, 16'h0070);
    cond = 13'h0000;
    host.wr(8'h03, 16'h0);
    rc(8'h78, 16'h0040);
    $display("status flags ended");
    // A reset in mid-run must restore the sequencing defaults.
    nrst = 1'b0;
    @(negedge clk) nrst = 1'b1;
    rc(8'h60, 16'h0000);
    rc(8'h61, 16'h0001);
    $display("reset test ended");
    tally_and_finish();
  end
endmodule : pss_regs_core_tb_top
